// ==== test/sdf_filter_monitor.sv ====
// port checker for the decimation filter
module sdf_filter_monitor #(
  parameter logic [16:0] SETTLE_2048 = 17'h0_1258,
  parameter logic [16:0] SETTLE_4096 = 17'h0_2258,
  parameter logic [16:0] SETTLE_8192 = 17'h0_4258,
  parameter logic [16:0] SETTLE_16384 = 17'h0_8258
) (
  input wire logic clock, // master clock
  input wire logic rst_n, // reset, active low
  input wire logic [2:0] decimation_ratio_sel, // ratio code
  input wire logic turbo_ratio_enable, // ratio 64
  input wire logic channel_enable, // channel on
  input wire logic [1:0] input_sel, // input selector
  input wire logic [2:0] gain_sel, // gain
  input wire logic resync, // restart pulse
  input wire logic modulator_clock, // master over two
  input wire logic [31:0] sample_data, // sample
  input wire logic sample_valid, // sample pulse
  input wire logic data_ready_n, // data ready, active low
  input wire logic fast_path_active, // fast path flag
  input wire logic [16:0] settle_cycles_left // settling count
);
  logic [3:0] lg;
  logic [16:0] tbl, tbl_q;
  logic [31:0] gap;
  logic [8:0] cfg, cfg_q;
  logic [1:0] nval;
  logic dirty, en_q, cause;
  assign lg = turbo_ratio_enable ? 4'h6 : 4'h7 + {1'b0, decimation_ratio_sel};
  assign cfg = {turbo_ratio_enable, decimation_ratio_sel, input_sel, gain_sel};
  assign cause = cfg != cfg_q || resync || (channel_enable && !en_q);
  always_comb begin
    case (lg)
      4'h6: tbl = 17'h0_02d8;
      4'h7: tbl = 17'h0_0358;
      4'h8: tbl = 17'h0_0458;
      4'h9: tbl = 17'h0_0658;
      4'ha: tbl = 17'h0_0a58;
      4'hb: tbl = SETTLE_2048;
      4'hc: tbl = SETTLE_4096;
      4'hd: tbl = SETTLE_8192;
      default: tbl = SETTLE_16384;
    endcase
  end
  // gap counts clocks since the last sample, dirty marks disturbed ones
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tbl_q <= 17'h0_0000;
      gap <= 32'h0000_0000;
      cfg_q <= 9'h000;
      en_q <= 1'b0;
      nval <= 2'h0;
      dirty <= 1'b1;
    end else begin
      tbl_q <= tbl;
      gap <= sample_valid ? 32'h0000_0001 : gap + 32'h0000_0001;
      cfg_q <= cfg;
      en_q <= channel_enable;
      nval <= (sample_valid && nval != 2'h2) ? nval + 2'h1 : nval;
      dirty <= sample_valid ? (cause || !channel_enable) :
        (dirty || cause || !channel_enable);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_mod_clk;
    $past(rst_n) |-> modulator_clock != $past(modulator_clock);
  endproperty
  a_mod_clk: assert property (p_mod_clk) else $error("bad modulator clock");
  property p_valid_pulse;
    sample_valid |=> !sample_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("long valid");
  property p_gap;
    sample_valid && !dirty |-> gap == (32'h0000_0002 << lg);
  endproperty
  a_gap: assert property (p_gap) else $error("wrong sample spacing");
  property p_hold;
    $past(rst_n) && !sample_valid |-> $stable(sample_data);
  endproperty
  a_hold: assert property (p_hold) else $error("sample changed alone");
  property p_data_ready_n;
    sample_valid |-> !data_ready_n [*4] ##1 data_ready_n;
  endproperty
  a_data_ready_n: assert property (p_data_ready_n) else $error("bad ready width");
  property p_data_ready_n_cause;
    $fell(data_ready_n) |-> sample_valid;
  endproperty
  a_data_ready_n_cause: assert property (p_data_ready_n_cause) else $error("stray ready");
  property p_fast_first;
    sample_valid && nval != 2'h2 |=> fast_path_active;
  endproperty
  a_fast_first: assert property (p_fast_first) else $error("no fast");
  property p_sinc3_after;
    sample_valid && nval == 2'h2 |=> !fast_path_active;
  endproperty
  a_sinc3_after: assert property (p_sinc3_after) else $error("fast late");
  property p_settle_load;
    resync |=> settle_cycles_left == tbl_q;
  endproperty
  a_settle_load: assert property (p_settle_load) else $error("bad load");
  property p_settle_dec;
    settle_cycles_left != 17'h0_0000 && !cause |=>
      settle_cycles_left == $past(settle_cycles_left) - 17'h0_0001;
  endproperty
  a_settle_dec: assert property (p_settle_dec) else $error("bad count");
  c_fast: cover property (sample_valid && fast_path_active);
  c_settled: cover property (sample_valid && settle_cycles_left == 17'h0_0000);
  c_resync: cover property (resync ##1 settle_cycles_left != 17'h0_0000);
endmodule

bind sdf_filter sdf_filter_monitor #(.SETTLE_2048(SETTLE_2048),
  .SETTLE_4096(SETTLE_4096), .SETTLE_8192(SETTLE_8192),
  .SETTLE_16384(SETTLE_16384)) mon_u (.clock, .rst_n, .decimation_ratio_sel,
  .turbo_ratio_enable, .channel_enable, .input_sel, .gain_sel, .resync,
  .modulator_clock, .sample_data, .sample_valid, .data_ready_n,
  .fast_path_active, .settle_cycles_left);

// ==== test/sdf_filter_tb_top.sv ====
// self-checking bench for the decimation filter
module sdf_filter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [16:0] S12 = 17'h0_00c8;
  localparam logic [16:0] S13 = 17'h0_012c;
  localparam logic [16:0] S14 = 17'h0_0190;
  logic clock, rst_n, level, modulator_bit, modulator_clock, resync;
  logic turbo_ratio_enable, channel_enable, sample_valid, data_ready_n;
  logic fast_path_active, exp_fast, pend;
  logic [2:0] decimation_ratio_sel, gain_sel;
  logic [1:0] input_sel;
  logic [31:0] sample_data, seed;
  logic [16:0] settle_cycles_left;
  int bad_count, num_checks, nsr, g;
  sdf_mod_model mod_u (.clock, .modulator_clock, .level, .modulator_bit);
  sdf_filter #(.SETTLE_4096(S12), .SETTLE_8192(S13), .SETTLE_16384(S14))
    dut_u (.clock, .rst_n, .modulator_bit, .decimation_ratio_sel,
    .turbo_ratio_enable, .channel_enable, .input_sel, .gain_sel, .resync,
    .modulator_clock, .sample_data, .sample_valid, .data_ready_n,
    .fast_path_active, .settle_cycles_left);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int settle_of(int lg);
    case (lg)
      6: return 17'h0_02d8;
      7: return 17'h0_0358;
      8: return 17'h0_0458;
      9: return 17'h0_0658;
      10: return 17'h0_0a58;
      11: return 17'h0_1258;
      12: return S12;
      13: return S13;
      default: return S14;
    endcase
  endfunction
  task automatic cyc;
    @(posedge clock);
  endtask
  task automatic chk_word(string n, logic [31:0] e, logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic chk_cnt(string n, int e, logic [16:0] v);
    num_checks++;
    if (v !== 17'(e)) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", n, e, v);
    end
  endtask
  task automatic chk_flag(string n, logic e, logic v);
    num_checks++;
    if (v !== e) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", n, e, v);
    end
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    do begin
      cyc;
      #1;
      n++;
    end while (sample_valid !== 1'b1 && n < 40000);
    if (sample_valid !== 1'b1) bad_count++;
  endtask
  task automatic wait_settled;
    for (int i = 0; i < 40000 && settle_cycles_left !== 17'h0_0000; i++) begin
      cyc;
      #1;
    end
    if (settle_cycles_left !== 17'h0_0000) bad_count++;
    wait_valid(g);
  endtask
  task automatic restart(int k);
    cyc;
    case (k)
      0: input_sel <= input_sel ^ (seed[1:0] | 2'b01);
      1: gain_sel <= gain_sel ^ (seed[4:2] | 3'b001);
      2: resync <= 1'b1;
      default: channel_enable <= 1'b1;
    endcase
    cyc;
    resync <= 1'b0;
    #1;
    chk_cnt("settle", settle_of(6), settle_cycles_left);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // reference model: path per sample since reset, value once settled
  always @(negedge clock) begin
    if (pend) chk_flag("fast_path_active", exp_fast, fast_path_active);
    pend = 1'b0;
    if (!rst_n) nsr = 0;
    else if (sample_valid === 1'b1) begin
      if (nsr < 2 || settle_cycles_left === 17'h0_0000)
        chk_word("sample_data", level ? 32'h2000_0000 : 32'he000_0000,
          sample_data);
      exp_fast = nsr < 2;
      nsr++;
      pend = 1'b1;
    end
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (100000) cyc;
    bad_count++;
    end_of_test;
  end
  initial begin
    {rst_n, resync, decimation_ratio_sel, input_sel, gain_sel} = '0;
    {level, turbo_ratio_enable, channel_enable, pend} = 4'b1110;
    seed = 32'h4e5e_b431;
    repeat (5) cyc;
    rst_n <= 1'b1;
    repeat (3) wait_valid(g);
    chk_cnt("gap", 128, 17'(g));
    wait_settled;
    for (int lg = 7; lg <= 14; lg++) begin
      cyc;
      turbo_ratio_enable <= 1'b0;
      decimation_ratio_sel <= 3'(lg - 7);
      cyc;
      #1;
      chk_cnt("settle", settle_of(lg), settle_cycles_left);
      if (lg <= 11) begin
        wait_valid(g);
        wait_valid(g);
        chk_cnt("gap", 2 << lg, 17'(g));
      end
    end
    cyc;
    turbo_ratio_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      if (k == 3) begin
        cyc;
        channel_enable <= 1'b0;
        repeat (20) cyc;
      end
      restart(k);
      wait_valid(g);
      chk_flag("settling", 1'b1, settle_cycles_left != 17'h0_0000);
    end
    cyc;
    level <= 1'b0;
    restart(2);
    wait_settled;
    cyc;
    rst_n <= 1'b0;
    repeat (5) cyc;
    rst_n <= 1'b1;
    repeat (3) wait_valid(g);
    end_of_test;
  end
endmodule

// ==== test/sdf_mod_model.sv ====
// modulator model feeding a bit stream of chosen density
module sdf_mod_model (
  input wire logic clock, // master clock
  input wire logic modulator_clock, // modulator clock from the filter
  input wire logic level, // bit value chosen by the bench
  output logic modulator_bit // bit stream into the filter
);
  timeunit 1ns;
  timeprecision 100ps;
  initial modulator_bit = 1'b1;
  // a new bit only after the edge that took the old one
  always @(posedge clock) begin
    if (modulator_clock === 1'b1) modulator_bit <= level;
  end
endmodule

// ==== verilog/sdf_cic_stage.sv ====
// one integrator or comb stage of the sinc3 chain
module sdf_cic_stage #(
  parameter int W = 32,
  parameter bit IS_COMB = 1'b0
) (
  input wire logic clock, // master clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic clr, // restart, clears the stage
  input wire logic en, // stage advances on this cycle
  input wire logic [W-1:0] din, // stage input
  output logic [W-1:0] dout // stage output, registered
);

  typedef struct packed {
    logic [W-1:0] acc;
    logic [W-1:0] dly;
  } sdf_stage_t;

  sdf_stage_t st;
  sdf_stage_t next_st;

  always_comb begin
    next_st = st;
    if (clr) begin
      next_st = '0;
    end else if (en) begin
      if (IS_COMB) begin
        // wrapping difference recovers the windowed sum
        next_st.acc = din - st.dly;
        next_st.dly = din;
      end else begin
        next_st.acc = st.acc + din;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.acc;

endmodule

// ==== verilog/sdf_filter.sv ====
// sinc decimation filter: fast-settling sinc1, sinc3 and sinc3 + sinc1

// Behaviour
// R1: the modulator strobe and input bit rate are the master clock over two.
// R2: one sample is produced per ratio count of modulator bits.
// R3: the ratio comes from a three-bit select, turbo forces ratio 64.
// R4: nine ratios are supported, the powers of two from 64 to 16384.
// R5: after reset samples come from the first-order fast-settling path.
// R6: after two conversions the sinc3 path is used until the next reset.
// R7: ratios 64 to 1024 pass the sinc3 output straight to the output.
// R8: ratios 2048 and up run sinc3 at 1024 then a sinc1 of 2 to 16.
// R9: enabling, input or gain change, or resync restarts settling.
// R10: samples keep coming while settling, never blanked or flagged.
// R11: the host tracks settling itself and drops unsettled samples.
// R12: settling is 728, 856, 1112, 1624, 2648 clocks for 64 to 1024.
// R13: settling is 4696, 8792, 16984, 33368 clocks for 2048 to 16384.
// R14: the first data ready fall after settling ends marks a good sample.
// R15: select codes 0 to 7 map to ratios 128 to 16384, turbo gives 64.
// R16: a ratio change restarts accumulators and counting like a resync.
module sdf_filter #(
  parameter logic [16:0] SETTLE_2048 = 17'h0_1258, // 4696 clocks
  parameter logic [16:0] SETTLE_4096 = 17'h0_2258, // 8792 clocks
  parameter logic [16:0] SETTLE_8192 = 17'h0_4258, // 16984 clocks
  parameter logic [16:0] SETTLE_16384 = 17'h0_8258 // 33368 clocks
) (
  input wire logic clock, // master clock, 100 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic modulator_bit, // modulator output, on clock domain
  input wire logic [2:0] decimation_ratio_sel, // ratio select code
  input wire logic turbo_ratio_enable, // forces ratio 64
  input wire logic channel_enable, // channel runs while high
  input wire logic [1:0] input_sel, // channel input selector
  input wire logic [2:0] gain_sel, // channel gain setting
  input wire logic resync, // one-cycle resynchronization pulse
  output logic modulator_clock, // modulator clock, master / 2
  output logic [31:0] sample_data, // signed sample, full scale 2**29
  output logic sample_valid, // one-cycle pulse per sample
  output logic data_ready_n, // low for a few cycles per sample
  output logic fast_path_active, // sample came from fast path
  output logic [16:0] settle_cycles_left // settling clocks remaining
);

  typedef struct packed {
    logic phase;
    logic [13:0] bits;
    logic [47:0][31:0] hist;
    logic [31:0] s3;
    logic [sdf_pkg::POST_W-1:0] post_acc;
    logic [sdf_pkg::FAST_W-1:0] fast_acc;
    logic [sdf_pkg::FAST_W-1:0] fast_hold;
    logic sinc3_due;
    logic conv_due;
    sdf_pkg::sdf_path_t path;
    logic [sdf_pkg::SETTLE_W-1:0] settle;
    logic [31:0] sample;
    logic valid;
    logic fast_out;
    logic [2:0] data_ready_n_cnt;
    logic [3:0] prev_log;
    logic prev_en;
    logic [1:0] prev_sel;
    logic [2:0] prev_gain;
  } sdf_state_t;

  sdf_state_t st;
  sdf_state_t next_st;

  logic [3:0] ratio_log;
  logic [3:0] sinc3_log;
  logic [3:0] post_log;
  logic [9:0] cnt3_last;
  logic [3:0] post_last;
  logic tick;
  logic run;
  logic dec3;
  logic conv_edge;
  logic restart;
  logic [4:0] sinc3_shift;
  logic [4:0] fast_shift;
  logic [31:0] sinc3_norm;
  logic [sdf_pkg::POST_W-1:0] post_sum;
  logic [31:0] post_val;
  logic [31:0] fast_val;
  logic [31:0] out_val;
  logic [sdf_pkg::FAST_W-1:0] fast_closed;
  logic [sdf_pkg::SETTLE_W-1:0] settle_load;

  logic [sdf_pkg::ACC_W-1:0] int_in [0:2];
  logic [sdf_pkg::ACC_W-1:0] int_out [0:2];
  logic snap;
  logic [5:0] lag1;
  logic [5:0] lag2;
  logic [5:0] lag3;
  logic [31:0] h1;
  logic [31:0] h2;
  logic [31:0] h3;
  logic [31:0] hd;
  logic [31:0] sinc3_raw;

  // ratio decode: turbo overrides the select code
  always_comb begin
    if (turbo_ratio_enable) begin
      ratio_log = sdf_pkg::LOG_TURBO; // [R3] [R15]
    end else begin
      ratio_log = sdf_pkg::LOG_BASE + {1'b0, decimation_ratio_sel}; // [R15]
    end
    // sinc3 never decimates beyond 1024
    if (ratio_log > sdf_pkg::LOG_SINC3_MAX) begin
      sinc3_log = sdf_pkg::LOG_SINC3_MAX; // [R8]
    end else begin
      sinc3_log = ratio_log; // [R7]
    end
    post_log = ratio_log - sinc3_log; // [R8]
  end

  assign cnt3_last = 10'((11'h001 << sinc3_log) - 11'h001);
  assign post_last = 4'((5'h01 << post_log) - 5'h01);

  // settling interval for the current ratio
  always_comb begin
    case (ratio_log)
      4'h6: settle_load = sdf_pkg::SETTLE_64; // [R12]
      4'h7: settle_load = sdf_pkg::SETTLE_128; // [R12]
      4'h8: settle_load = sdf_pkg::SETTLE_256; // [R12]
      4'h9: settle_load = sdf_pkg::SETTLE_512; // [R12]
      4'ha: settle_load = sdf_pkg::SETTLE_1024; // [R12]
      4'hb: settle_load = SETTLE_2048; // [R13]
      4'hc: settle_load = SETTLE_4096; // [R13]
      4'hd: settle_load = SETTLE_8192; // [R13]
      4'he: settle_load = SETTLE_16384; // [R13]
      default: settle_load = SETTLE_16384;
    endcase
  end

  // one modulator bit every second master clock
  assign tick = st.phase; // [R1]
  assign run = tick & channel_enable;
  // decimation points sit on a free count of bits, so a restart keeps them
  assign dec3 = run & ((st.bits[9:0] & cnt3_last) == cnt3_last); // [R2]
  assign conv_edge = dec3
    & ((st.bits[13:10] & post_last) == post_last); // [R2] [R4]
  assign snap = run & (st.bits[5:0] == 6'h3f);

  assign restart = (channel_enable & ~st.prev_en) // [R9]
    | (input_sel != st.prev_sel) // [R9]
    | (gain_sel != st.prev_gain) // [R9]
    | resync // [R9]
    | (ratio_log != st.prev_log); // [R16]

  // sinc3: integrators at the bit rate, combs from snapshots every 64 bits
  assign int_in[0] = {{(sdf_pkg::ACC_W-1){1'b0}}, modulator_bit};
  assign int_in[1] = int_out[0];
  assign int_in[2] = int_out[1];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stage
      sdf_cic_stage #(
        .W(sdf_pkg::ACC_W),
        .IS_COMB(1'b0)
      ) u_int (
        .clock(clock),
        .rst_n(rst_n),
        .clr(1'b0), // history must survive a restart to settle in time
        .en(run),
        .din(int_in[gi]),
        .dout(int_out[gi])
      );
    end
  endgenerate

  // third difference over lags of one, two and three sinc3 windows
  assign lag1 = (6'h01 << (sinc3_log - 4'h6)) - 6'h01;
  assign lag2 = {lag1[4:0], 1'b1};
  assign lag3 = lag1 + lag2 + 6'h01;
  assign h1 = st.hist[lag1];
  assign h2 = st.hist[lag2];
  assign h3 = st.hist[lag3];
  assign hd = h2 - h1;
  assign sinc3_raw = int_out[2] - h3 + (hd << 1) + hd; // [R7] [R8]

  // scale every path to the same full scale of 2**30
  assign sinc3_shift = 5'(sdf_pkg::NORM_LOG
    - 6'(sdf_pkg::SINC3_ORDER * {2'b00, sinc3_log}));
  assign fast_shift = 5'(sdf_pkg::NORM_LOG - {2'b00, ratio_log});
  assign sinc3_norm = st.s3 << sinc3_shift;
  assign post_sum = st.post_acc + {3'b000, sinc3_norm};
  // sinc1 after sinc3 averages 2 to 16 decimated values
  assign post_val = 32'(post_sum >> post_log); // [R8]
  assign fast_val = {17'h0_0000, st.fast_hold} << fast_shift; // [R5]
  assign fast_closed = st.fast_acc + {14'h0000, modulator_bit};

  always_comb begin
    if (st.path == sdf_pkg::SDF_SINC3) begin
      out_val = post_val; // [R6] [R7] [R8]
    end else begin
      out_val = fast_val; // [R5]
    end
  end

  always_comb begin
    next_st = st;
    next_st.phase = ~st.phase; // [R1]
    next_st.prev_log = ratio_log;
    next_st.prev_en = channel_enable;
    next_st.prev_sel = input_sel;
    next_st.prev_gain = gain_sel;
    next_st.valid = 1'b0;
    if (st.data_ready_n_cnt != 3'h0) begin
      next_st.data_ready_n_cnt = st.data_ready_n_cnt - 3'h1;
    end
    if (st.settle != sdf_pkg::RESET_SETTLE) begin
      next_st.settle = st.settle - 17'h0_0001;
    end

    if (run) begin
      next_st.bits = st.bits + 14'h0001; // [R2]
      if (snap) begin
        next_st.hist = {st.hist[46:0], int_out[2]};
      end
      if (conv_edge) begin
        next_st.fast_hold = fast_closed; // [R5]
        next_st.fast_acc = '0;
      end else begin
        next_st.fast_acc = fast_closed;
      end
    end
    if (dec3) begin
      next_st.s3 = sinc3_raw; // [R7]
    end
    // the sinc3 value is registered one cycle after the decimation strobe
    next_st.sinc3_due = dec3;
    next_st.conv_due = conv_edge;
    if (st.sinc3_due) begin
      if (st.conv_due) begin
        next_st.post_acc = '0;
      end else begin
        next_st.post_acc = post_sum; // [R8]
      end
    end
    if (st.conv_due) begin
      // issued whether or not the filter has settled
      next_st.sample = out_val - sdf_pkg::MIDSCALE; // [R10] [R11]
      next_st.valid = 1'b1; // [R2] [R10]
      next_st.data_ready_n_cnt = sdf_pkg::DATA_READY_N_LOW_CYCLES; // [R14]
      next_st.fast_out = (st.path != sdf_pkg::SDF_SINC3);
      case (st.path)
        sdf_pkg::SDF_FAST_FIRST: begin
          next_st.path = sdf_pkg::SDF_FAST_SECOND; // [R6]
        end
        sdf_pkg::SDF_FAST_SECOND: begin
          next_st.path = sdf_pkg::SDF_SINC3; // [R6]
        end
        sdf_pkg::SDF_SINC3: begin
          next_st.path = sdf_pkg::SDF_SINC3; // [R6]
        end
        default: begin
          next_st.path = sdf_pkg::SDF_FAST_FIRST;
        end
      endcase
    end

    if (restart) begin
      // path, history and bit count survive: the sinc3 settles from old data
      next_st.settle = settle_load; // [R9] [R12] [R13]
      next_st.post_acc = '0; // [R16]
      next_st.fast_acc = '0; // [R16]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
      st.path <= sdf_pkg::SDF_FAST_FIRST; // [R5]
      st.sample <= sdf_pkg::RESET_SAMPLE;
      st.settle <= sdf_pkg::RESET_SETTLE;
    end else begin
      st <= next_st;
    end
  end

  assign modulator_clock = st.phase; // [R1]
  assign sample_data = st.sample;
  assign sample_valid = st.valid;
  assign data_ready_n = (st.data_ready_n_cnt == 3'h0); // [R14]
  assign fast_path_active = st.fast_out;
  assign settle_cycles_left = st.settle; // [R11] [R14]

endmodule

// ==== verilog/sdf_pkg.sv ====
// constants and types shared by the decimation filter modules
package sdf_pkg;

  // modulator strobe runs at master clock / MOD_DIV
  localparam int MOD_DIV = 2;

  // log2 of the oversampling ratio
  localparam logic [3:0] LOG_TURBO = 4'h6;
  localparam logic [3:0] LOG_BASE = 4'h7;
  localparam logic [3:0] LOG_SINC3_MAX = 4'ha;
  localparam logic [3:0] LOG_MAX = 4'he;

  // all paths are scaled so that full scale equals 2**NORM_LOG
  localparam logic [5:0] NORM_LOG = 6'h1e;
  localparam logic [5:0] SINC3_ORDER = 6'h03;
  localparam logic [31:0] MIDSCALE = 32'h2000_0000;

  // widths
  localparam int ACC_W = 32;
  localparam int POST_W = 35;
  localparam int FAST_W = 15;
  localparam int SETTLE_W = 17;

  // settling intervals in master clock periods, ratios 64 to 1024
  localparam logic [16:0] SETTLE_64 = 17'h0_02d8;
  localparam logic [16:0] SETTLE_128 = 17'h0_0358;
  localparam logic [16:0] SETTLE_256 = 17'h0_0458;
  localparam logic [16:0] SETTLE_512 = 17'h0_0658;
  localparam logic [16:0] SETTLE_1024 = 17'h0_0a58;

  // cycles data_ready_n stays low after each sample
  localparam logic [2:0] DATA_READY_N_LOW_CYCLES = 3'h4;

  // reset values
  localparam logic [31:0] RESET_SAMPLE = 32'h0000_0000;
  localparam logic [16:0] RESET_SETTLE = 17'h0_0000;

  // output path selection, gray coded along the startup sequence
  typedef enum logic [1:0] {
    SDF_FAST_FIRST = 2'b00,
    SDF_FAST_SECOND = 2'b01,
    SDF_SINC3 = 2'b11
  } sdf_path_t;

endpackage
